// file: src/ee_slave.sv
/*
  Internal two-wire serial data store with its CPU port register, reached
  over a classic Wishbone slave. Assumes the CPU bit-bangs the bus master
  through the port register and that both bus lines stay inside the chip.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ee_slave_regs.svh"

module ee_slave #(
  parameter int WRITE_BUSY_CYCLES = `EE_WRITE_BUSY_CYCLES,
  parameter int DEPTH = 16,
  parameter int ADDR_W = 4,
  parameter logic [3:0] DEV_CODE = 4'h5 // arbitrary device code
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic SDA_LINE,
  output logic SCL_LINE,
  output logic EE_BUSY
);

  localparam int BW = $clog2(WRITE_BUSY_CYCLES + 1);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (WRITE_BUSY_CYCLES < 1)
  begin : g_chk_busy
    $error("write busy count must be at least one");
  end
  if (DEPTH != (1 << ADDR_W) || ADDR_W > 8)
  begin : g_chk_depth
    $error("depth must be two to the pointer width, pointer at most 8 bits");
  end

  // ****************************************
  // state
  // ****************************************
  logic [1:0] port_r;
  logic pull_r;
  logic ack_r;
  logic [31:0] dat_r;
  ee_slave_pkg::lines_t cur;
  ee_slave_pkg::lines_t prev_r;
  ee_slave_pkg::state_t state_r;
  ee_slave_pkg::phase_t phase_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] buf_r;
  logic data_ok_r;
  logic rw_r;
  logic mack_r;
  logic [ADDR_W-1:0] ptr_r;
  logic busy_r;
  logic [BW-1:0] busy_cnt_r;
  logic [7:0] mem_r [DEPTH];
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic commit;
  logic ctrl_match;
  logic [5:0] idx;
  logic bus_req;

  // ****************************************
  // wired lines and bus conditions
  // ****************************************
  // the store only ever pulls low, so the line is a wired-AND
  assign cur = '{scl: port_r[1], sda: port_r[0] & ~pull_r};
  // observation only: neither line is routed to a pad
  assign SDA_LINE = cur.sda;
  assign SCL_LINE = cur.scl;
  assign EE_BUSY = busy_r;

  assign scl_rise = cur.scl & ~prev_r.scl;
  assign scl_fall = ~cur.scl & prev_r.scl;
  // a data edge counts only while the clock stayed high across it
  assign start_det = cur.scl & prev_r.scl & prev_r.sda & ~cur.sda;
  assign stop_det = cur.scl & prev_r.scl & ~prev_r.sda & cur.sda;
  assign byte_done = scl_fall && state_r == ee_slave_pkg::ST_RX
    && cnt_r == `EE_BITS_PER_BYTE;
  assign ctrl_match = shift_r[7:4] == DEV_CODE && !busy_r;
  // only a full acknowledged data byte with no bits after it is written;
  // the clock rise that leads into the stop is no bit of its own
  assign commit = stop_det && state_r == ee_slave_pkg::ST_RX
    && phase_r == ee_slave_pkg::PH_DATA && data_ok_r
    && cnt_r <= 4'h1 && !rw_r;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      prev_r <= '{scl: 1'b1, sda: 1'b1};
    else
      prev_r <= cur;
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  assign idx = WB_ADR_I[7:2];
  assign bus_req = WB_CYC_I & WB_STB_I;
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req & ~ack_r;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      dat_r <= 32'h0;
    else if (bus_req & ~ack_r)
    begin
      dat_r <= 32'h0;
      if (idx == `EE_PORT_IDX)
      begin
        dat_r[`EE_SDA_BIT] <= cur.sda;
        dat_r[`EE_SCL_BIT] <= cur.scl;
      end
      else if (idx == `EE_STAT_IDX)
      begin
        dat_r[`EE_STAT_BUSY_BIT] <= busy_r;
        dat_r[`EE_STAT_PTR_LSB +: ADDR_W] <= ptr_r;
      end
    end
  end

  // the write lands on the same edge the master samples the answer
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      port_r <= `EE_PORT_RST;
    else if (bus_req && ack_r && WB_WE_I && WB_SEL_I[0] && idx == `EE_PORT_IDX)
      port_r <= {WB_DAT_I[`EE_SCL_BIT], WB_DAT_I[`EE_SDA_BIT]};
  end

  // ****************************************
  // bus protocol engine
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_r <= ee_slave_pkg::ST_IDLE;
      phase_r <= ee_slave_pkg::PH_CTRL;
      cnt_r <= 4'h0;
      pull_r <= 1'b0;
      rw_r <= 1'b0;
      data_ok_r <= 1'b0;
      mack_r <= 1'b0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      buf_r <= 8'h00;
      ptr_r <= '0;
    end
    else if (stop_det)
    begin
      state_r <= ee_slave_pkg::ST_IDLE;
      pull_r <= 1'b0;
      data_ok_r <= 1'b0;
    end
    else if (start_det)
    begin
      // repeated start drops any write but keeps a fresh pointer
      state_r <= ee_slave_pkg::ST_RX;
      phase_r <= ee_slave_pkg::PH_CTRL;
      cnt_r <= 4'h0;
      pull_r <= 1'b0;
      data_ok_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ee_slave_pkg::ST_IDLE:
        begin
          pull_r <= 1'b0;
        end
        ee_slave_pkg::ST_RX:
        begin
          if (scl_rise && cnt_r != `EE_BITS_PER_BYTE)
          begin
            shift_r <= {shift_r[6:0], cur.sda};
            cnt_r <= cnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_r <= 4'h0;
            unique case (phase_r)
              ee_slave_pkg::PH_CTRL:
              begin
                if (ctrl_match)
                begin
                  pull_r <= 1'b1;
                  rw_r <= shift_r[0];
                  state_r <= ee_slave_pkg::ST_ACK;
                end
                else
                  state_r <= ee_slave_pkg::ST_IDLE;
              end
              ee_slave_pkg::PH_ADDR:
              begin
                ptr_r <= shift_r[ADDR_W-1:0];
                pull_r <= 1'b1;
                state_r <= ee_slave_pkg::ST_ACK;
              end
              default:
              begin
                // a later byte replaces the earlier one
                buf_r <= shift_r;
                data_ok_r <= 1'b1;
                pull_r <= 1'b1;
                state_r <= ee_slave_pkg::ST_ACK;
              end
            endcase
          end
          // a stray bit spoils the buffered byte once its pulse is over
          else if (scl_fall && phase_r == ee_slave_pkg::PH_DATA)
            data_ok_r <= 1'b0;
        end
        ee_slave_pkg::ST_ACK:
        begin
          // held low from one falling edge to the next
          if (scl_fall)
          begin
            if (phase_r == ee_slave_pkg::PH_CTRL && rw_r)
            begin
              tx_r <= mem_r[ptr_r];
              pull_r <= ~mem_r[ptr_r][7];
              cnt_r <= 4'h0;
              state_r <= ee_slave_pkg::ST_TX;
            end
            else
            begin
              pull_r <= 1'b0;
              state_r <= ee_slave_pkg::ST_RX;
              if (phase_r == ee_slave_pkg::PH_CTRL)
                phase_r <= ee_slave_pkg::PH_ADDR;
              else
                phase_r <= ee_slave_pkg::PH_DATA;
            end
          end
        end
        ee_slave_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_r == `EE_LAST_TX_BIT)
            begin
              pull_r <= 1'b0;
              ptr_r <= ptr_r + 1'b1;
              state_r <= ee_slave_pkg::ST_MACK;
            end
            else
            begin
              // new bit only while the clock is low
              pull_r <= ~tx_r[6];
              tx_r <= {tx_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        ee_slave_pkg::ST_MACK:
        begin
          if (scl_rise)
            mack_r <= ~cur.sda;
          else if (scl_fall)
          begin
            if (mack_r)
            begin
              tx_r <= mem_r[ptr_r];
              pull_r <= ~mem_r[ptr_r][7];
              cnt_r <= 4'h0;
              state_r <= ee_slave_pkg::ST_TX;
            end
            else
            begin
              pull_r <= 1'b0;
              state_r <= ee_slave_pkg::ST_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= ee_slave_pkg::ST_IDLE;
          pull_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // storage and write cycle
  // ****************************************
  // contents are not reset, like the real cells
  always_ff @(posedge CLK)
  begin
    if (commit)
      mem_r[ptr_r] <= buf_r;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
    end
    else if (commit)
    begin
      busy_r <= 1'b1;
      busy_cnt_r <= BW'(WRITE_BUSY_CYCLES - 1);
    end
    else if (busy_r)
    begin
      if (busy_cnt_r == '0)
        busy_r <= 1'b0;
      else
        busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  busy_no_ack_a: assert property (
    byte_done && phase_r == ee_slave_pkg::PH_CTRL && busy_r && !start_det && !stop_det
    |=> state_r == ee_slave_pkg::ST_IDLE && !pull_r)
    else $error("control byte acknowledged while busy");

  ack_low_a: assert property (
    state_r == ee_slave_pkg::ST_ACK && cur.scl |-> !cur.sda)
    else $error("acknowledge not low while clock high");

  start_seen_a: assert property (
    start_det && !stop_det |=> state_r == ee_slave_pkg::ST_RX && cnt_r == 4'h0
      && phase_r == ee_slave_pkg::PH_CTRL)
    else $error("start not taken");

  stop_seen_a: assert property (
    stop_det |=> state_r == ee_slave_pkg::ST_IDLE && !pull_r)
    else $error("stop not taken");

  write_lands_a: assert property (
    commit |=> mem_r[$past(ptr_r)] == $past(buf_r) && busy_r && ptr_r == $past(ptr_r))
    else $error("write not committed at pointer");

  abort_quiet_a: assert property (
    stop_det && !commit && !busy_r |=> !busy_r)
    else $error("aborted write started a cycle");

  busy_load_a: assert property (
    commit |=> busy_r && busy_cnt_r == BW'(WRITE_BUSY_CYCLES - 1))
    else $error("busy period not loaded");

  nack_release_a: assert property (
    state_r == ee_slave_pkg::ST_MACK && scl_fall && !mack_r && !start_det && !stop_det
    |=> !pull_r && state_r == ee_slave_pkg::ST_IDLE)
    else $error("line not released after master nack");

  ptr_step_a: assert property (
    state_r == ee_slave_pkg::ST_TX && scl_fall && cnt_r == `EE_LAST_TX_BIT
      && !start_det && !stop_det
    |=> ptr_r == $past(ptr_r) + 1'b1)
    else $error("pointer did not advance after read byte");

  addr_load_a: assert property (
    byte_done && phase_r == ee_slave_pkg::PH_ADDR && !start_det && !stop_det
    |=> ptr_r == $past(shift_r[ADDR_W-1:0]))
    else $error("pointer not loaded from address byte");

  drive_low_clk_a: assert property (
    $changed(pull_r) && !$past(start_det) && !$past(stop_det)
      && !start_det && !stop_det |-> !cur.scl)
    else $error("data changed while clock high");

  write_cov_c: cover property (commit);
  read_more_c: cover property (state_r == ee_slave_pkg::ST_MACK && scl_fall && mack_r);
  busy_poll_c: cover property (byte_done && phase_r == ee_slave_pkg::PH_CTRL && busy_r);

endmodule
`default_nettype wire

// file: src/ee_slave_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  internal serial data store. Assumes a 20 MHz system clock.
*/
`ifndef EE_SLAVE_REGS_SVH
`define EE_SLAVE_REGS_SVH

// register indexes, byte address is four times the index
`define EE_PORT_IDX 6'h06
`define EE_STAT_IDX 6'h07

// port register fields
`define EE_SDA_BIT 6
`define EE_SCL_BIT 7
`define EE_PORT_RST 2'h3

// status register fields
`define EE_STAT_BUSY_BIT 0
`define EE_STAT_PTR_LSB 4

// timing
`define EE_CLK_MHZ 20
`define EE_WRITE_BUSY_US 4000
`define EE_WRITE_BUSY_CYCLES (`EE_WRITE_BUSY_US * `EE_CLK_MHZ)

// protocol counts
`define EE_BITS_PER_BYTE 4'h8
`define EE_LAST_TX_BIT 4'h7

`endif

// file: src/ee_slave_pkg.sv
/*
  Types shared by the internal serial data store.
  Assumes the constants header is included by the design file.
*/
package ee_slave_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } state_t;

  typedef enum logic [1:0] {
    PH_CTRL = 2'h0,
    PH_ADDR = 2'h1,
    PH_DATA = 2'h2
  } phase_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } lines_t;

endpackage

// file: verif/ee_cpu_master.sv
/*
  CPU-side model: Wishbone master that bit-bangs the two-wire bus
  through the port register. Callers enter each task just after a
  rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ee_cpu_master (
  input wire logic clk,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // ****************************************
  // bus and line tasks
  // ****************************************
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  task bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
           input logic [3:0] sel, output logic [31:0] rd);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= adr;
    dat_o <= wd;
    sel_o <= sel;
    do
      @(posedge clk);
    while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    @(posedge clk);
  endtask

  // one line changes per write, never both
  task set(input logic c, input logic d);
    logic [31:0] x;
    bus(1'b1, 8'h18, {24'h0, c, d, 6'h00}, 4'h1, x);
  endtask

  task bitx(input logic b, output logic s);
    logic [31:0] x;
    set(1'b0, b);
    set(1'b1, b);
    bus(1'b0, 8'h18, 32'h0, 4'hF, x);
    s = x[6];
    set(1'b0, b);
  endtask

  task start();
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    set(1'b1, 1'b0);
    set(1'b0, 1'b0);
  endtask

  task stop();
    set(1'b0, 1'b0);
    set(1'b1, 1'b0);
    set(1'b1, 1'b1);
  endtask

  task tx(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask

  task rx(input logic mack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, s);
      v[i] = s;
    end
    bitx(~mack, s);
  endtask
endmodule
`default_nettype wire

// file: verif/internal_serial_eeprom_slave_tb_top.sv
/*
  Self-checking bench for the serial data store: a byte array model
  is compared with every read byte; acknowledges are checked except
  those of the pointer set before a read.
  Assumes the CPU model in ee_cpu_master drives the register bus.
*/
`timescale 1ns/1ns
`default_nettype none
module internal_serial_eeprom_slave_tb_top;
  // ****************************************
  // set-up
  // ****************************************
  localparam int BUSY = 400;
  localparam logic [3:0] DEV = 4'h6; // arbitrary device code
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc, stb, we, ack, sda, scl, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rdat, r;
  logic [7:0] mem [16];
  logic [3:0] ptr;
  logic k;
  int failures = 0;
  int check_count = 0;

  ee_slave #(.WRITE_BUSY_CYCLES(BUSY), .DEV_CODE(DEV)) uut (.CLK(clk),
    .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SDA_LINE(sda), .SCL_LINE(scl), .EE_BUSY(busy));
  ee_cpu_master cpu (.clk(clk), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));

  always #25 clk = ~clk;

  // ****************************************
  // checks and operations
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  task report_and_stop();
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // nd data bytes, then xb stray bits; commits only on whole bytes
  task wr_op(input logic [3:0] a, input int nd, input int xb);
    logic s;
    logic [7:0] d;
    cpu.start();
    cpu.tx({DEV, 3'($urandom), 1'b0}, k);
    chk(32'(k), 32'h1);
    cpu.tx({4'($urandom), a}, k);
    chk(32'(k), 32'h1);
    ptr = a;
    for (int i = 0; i < nd; i++)
    begin
      d = 8'($urandom);
      cpu.tx(d, k);
      chk(32'(k), 32'h1);
    end
    repeat (xb) cpu.bitx(1'b1, s);
    cpu.stop();
    if (nd > 0 && xb == 0)
    begin
      mem[a] = d;
      cpu.start();
      cpu.tx({DEV, 3'h0, 1'b0}, k);
      chk(32'(k), 32'h0);
      chk(32'(busy), 32'h1);
      cpu.bus(1'b0, 8'h1C, 32'h0, 4'hF, r);
      chk(r, {24'h0, ptr, 4'h1});
      while (k !== 1'b1)
      begin
        cpu.start();
        cpu.tx({DEV, 3'h0, 1'b0}, k);
      end
      cpu.stop();
    end
    else
    begin
      repeat (3) @(posedge clk);
      chk(32'(busy), 32'h0);
    end
  endtask

  task rd_seq(input logic setp, input logic [3:0] a, input int n);
    logic [7:0] v;
    cpu.start();
    if (setp)
    begin
      cpu.tx({DEV, 3'h0, 1'b0}, k);
      cpu.tx({4'($urandom), a}, k);
      ptr = a;
      cpu.start();
    end
    cpu.tx({DEV, 3'($urandom), 1'b1}, k);
    chk(32'(k), 32'h1);
    for (int i = 0; i < n; i++)
    begin
      cpu.rx(i < n - 1, v);
      chk(32'(v), 32'(mem[ptr]));
      ptr = ptr + 4'h1;
    end
    cpu.stop();
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    void'($urandom(32'h82387913));
    repeat (3) @(posedge clk);
    chk(32'(sda), 32'h1);
    chk(32'(scl), 32'h1);
    reset_n <= 1'b1;
    @(posedge clk);
    cpu.bus(1'b0, 8'h18, 32'h0, 4'hF, r);
    chk(r, 32'hC0);
    cpu.bus(1'b1, 8'h18, 32'h0, 4'h0, r);
    cpu.bus(1'b0, 8'h3C, 32'h0, 4'hF, r);
    chk(r, 32'h0);
    cpu.bus(1'b0, 8'h18, 32'h0, 4'hF, r);
    chk(r, 32'hC0);
    cpu.start();
    cpu.tx({~DEV, 4'h0}, k);
    chk(32'(k), 32'h0);
    cpu.stop();
    for (int a = 0; a < 16; a++)
      wr_op(4'(a), 1, 0);
    cpu.bus(1'b0, 8'h1C, 32'h0, 4'hF, r);
    chk(r, {24'h0, ptr, 4'h0});
    rd_seq(1'b0, 4'h0, 1);
    rd_seq(1'b0, 4'h0, 2);
    rd_seq(1'b1, 4'hE, 4);
    wr_op(4'h3, 0, 0);
    wr_op(4'h5, 2, 0);
    wr_op(4'h6, 1, 3);
    rd_seq(1'b1, 4'h3, 4);
    report_and_stop();
  end

  initial
  begin
    #3000000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
